// *** bench/test_vdsc_top.sv ***
// Register and control bench for the divider sync block
`timescale 1ns/1ns
module test_vdsc_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic first_divider_run, second_divider_run, feedback_delay_divider_reset;
   logic [31:0] paddr, pwdata, prdata, q;
   logic [3:0] pstrb, first_divider_ratio, second_divider_ratio, output_divider_reset;
   logic [23:0] tab [6] = '{24'h447F00, 24'h44001F, 24'h400006, 24'h402004, 24'h04150A, 24'h0};
   logic [11:0] pw [5] = '{12'h012, 12'h022, 12'h101, 12'h201, 12'h003};
   int miscompares = 0;
   int checked = 0;
   wire [1:0] runs = {second_divider_run, first_divider_run};
   vdsc_top dut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .first_divider_run(first_divider_run),
      .first_divider_ratio(first_divider_ratio),
      .second_divider_run(second_divider_run),
      .second_divider_ratio(second_divider_ratio),
      .output_divider_reset(output_divider_reset),
      .feedback_delay_divider_reset(feedback_delay_divider_reset)
   );
   // Compare and count
   task automatic chk(input string n, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask
   // One APB transfer, released at the edge that samples pready
   task automatic xfer(input logic w, input logic [31:0] a, d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Write, then let the outputs follow
   task automatic wr(input logic [31:0] a, d);
      xfer(1'b1, a, d);
      @(posedge pclk);
      #1;
   endtask
   task automatic rd(input logic [31:0] a, e);
      xfer(1'b0, a, 32'h0);
      chk("read data", e, q);
   endtask
   task automatic final_report;
      if (miscompares == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Watchdog
   initial begin
      repeat (3000) @(posedge pclk);
      miscompares++;
      final_report();
   end
   // Test sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hF;
      presetn = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(32'h480, 32'h20);
      rd(32'h484, 32'h44);
      rd(32'h488, 32'h00);
      chk("run", 2'h1, runs);
      wr(32'h488, 32'hFF);
      rd(32'h488, 32'h7F);
      wr(32'h480, 32'hFF);
      rd(32'h480, 32'h77);
      foreach (tab[i]) begin
         wr(32'h480, {24'h0, tab[i][23:16]});
         wr(32'h488, {24'h0, tab[i][15:8]});
         chk("sync", tab[i][7:0], {feedback_delay_divider_reset, output_divider_reset});
      end
      foreach (pw[i]) begin
         wr(32'h480, {24'h0, pw[i][11:4]});
         chk("run", pw[i][3:0], runs);
      end
      for (int c = 0; c < 16; c++) begin
         wr(32'h484, {24'h0, c[3:0], c[3:0]});
         chk("ratio", {c[3:0], c[3:0], {2{c >= 2 && c <= 11}}},
            {second_divider_ratio, first_divider_ratio, runs});
      end
      xfer(1'b0, 32'h48C, 32'h0);
      chk("error", 1'b1, err);
      // Write without the low byte strobe must leave the ratios alone
      @(posedge pclk);
      pstrb <= 4'hE;
      wr(32'h484, 32'h33);
      rd(32'h484, 32'hFF);
      final_report();
   end
endmodule

// *** bench/vdsc_top_sva.sv ***
// Port checks for the divider sync control block
`timescale 1ns/1ns
module vdsc_top_sva (
   input wire logic pclk, presetn, psel, penable, pwrite, pslverr,
   input wire logic [31:0] paddr, pwdata,
   input wire logic [3:0] pstrb, first_divider_ratio, output_divider_reset,
   input wire logic first_divider_run, second_divider_run, feedback_delay_divider_reset
);
   logic acc, wc, wr;
   // Access phase and write strobes for the control and ratio registers
   assign acc = psel && penable;
   assign wc = acc && pwrite && pstrb[0] && paddr == 32'h480;
   assign wr = acc && pwrite && pstrb[0] && paddr == 32'h484;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================
   // Output relations
   sync_clear_a: assert property (wc && !pwdata[6] && !pwdata[2] |-> ##2
      output_divider_reset == 4'h0 && !feedback_delay_divider_reset) else $error("sync stuck");
   second_reach_a: assert property (wc && !pwdata[2] |-> ##2 !output_divider_reset[0]
      && !output_divider_reset[3] && !feedback_delay_divider_reset) else $error("sync spread");
   first_stop_a: assert property (wc && pwdata[1:0] != 2'h0 |-> ##2
      !first_divider_run) else $error("first divider runs");
   second_stop_a: assert property (wc && pwdata[5:4] != 2'h0 |-> ##2
      !second_divider_run) else $error("second divider runs");
   ratio_copy_a: assert property (wr |-> ##2
      first_divider_ratio == $past(pwdata[3:0], 2)) else $error("ratio not taken");
   first_bad_a: assert property (wr && !(pwdata[3:0] inside {[4'h2:4'hB]}) |-> ##2
      !first_divider_run) else $error("first bad ratio runs");
   second_bad_a: assert property (wr && !(pwdata[7:4] inside {[4'h2:4'hB]}) |-> ##2
      !second_divider_run) else $error("second bad ratio runs");
   bad_addr_a: assert property (pslverr == (acc && !(paddr inside
      {32'h480, 32'h484, 32'h488}))) else $error("error response wrong");
endmodule
bind vdsc_top vdsc_top_sva u_sva (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .pslverr(pslverr),
   .paddr(paddr),
   .pwdata(pwdata),
   .pstrb(pstrb),
   .first_divider_ratio(first_divider_ratio),
   .output_divider_reset(output_divider_reset),
   .first_divider_run(first_divider_run),
   .second_divider_run(second_divider_run),
   .feedback_delay_divider_reset(feedback_delay_divider_reset)
);

// *** hdl/vdsc_pkg.sv ***
// Constants for the oscillator divider and distribution sync control block
// Functional notes
// RULE1: Control bit 6 sends a sync to every output divider fed by the second divider while set.
// RULE2: Control bit 2 sends a sync to every output divider fed by the first divider.
// RULE3: A set sync bit holds the affected output dividers in reset and clearing it releases them.
// RULE4: Control bits 4 and 0 hold the second and first divider in reset, both reset to 0.
// RULE5: First divider ratio in bits 3:0 divides by codes 2 to 11, else powered down, reset 4.
// RULE6: Second divider ratio in bits 7:4 divides by codes 2 to 11, else powered down, reset 4.
// RULE7: Mask bits 6 and 5 let output dividers two and one ignore the second divider sync.
// RULE8: Mask bits 4 to 0 let feedback delay and outputs three to zero ignore the first sync.
// RULE9: Power-down bits 5 and 1 stop the second and first divider; second resets powered down.
package vdsc_pkg;
   // ==========================================
   // Register indices; byte address is four times the index
   localparam logic [11:0] VDSC_IDX_CONTROL = 12'h120;
   localparam logic [11:0] VDSC_IDX_RATIOS = 12'h121;
   localparam logic [11:0] VDSC_IDX_MASKS = 12'h122;
   localparam logic [13:0] VDSC_ADDR_CONTROL = {VDSC_IDX_CONTROL, 2'h0};
   localparam logic [13:0] VDSC_ADDR_RATIOS = {VDSC_IDX_RATIOS, 2'h0};
   localparam logic [13:0] VDSC_ADDR_MASKS = {VDSC_IDX_MASKS, 2'h0};
   // ==========================================
   // Control register fields
   localparam int VDSC_CTL_FIRST_RESET = 0;
   localparam int VDSC_CTL_FIRST_PD = 1;
   localparam int VDSC_CTL_FIRST_SYNC = 2;
   localparam int VDSC_CTL_SECOND_RESET = 4;
   localparam int VDSC_CTL_SECOND_PD = 5;
   localparam int VDSC_CTL_SECOND_SYNC = 6;
   localparam logic [7:0] VDSC_CTL_WMASK = 8'h77;
   localparam logic [7:0] VDSC_CTL_RESET = 8'h20;
   // ==========================================
   // Ratio register fields
   localparam int VDSC_RAT_FIRST_LSB = 0;
   localparam int VDSC_RAT_SECOND_LSB = 4;
   localparam logic [7:0] VDSC_RAT_RESET = 8'h44;
   localparam logic [3:0] VDSC_RATIO_MIN = 4'h2;
   localparam logic [3:0] VDSC_RATIO_MAX = 4'hB;
   // ==========================================
   // Mask register fields
   localparam int VDSC_MSK_FIRST_LSB = 0;
   localparam int VDSC_MSK_FIRST_FEEDBACK = 4;
   localparam int VDSC_MSK_SECOND_ONE = 5;
   localparam int VDSC_MSK_SECOND_TWO = 6;
   localparam logic [7:0] VDSC_MSK_WMASK = 8'h7F;
   localparam logic [7:0] VDSC_MSK_RESET = 8'h00;
endpackage

// *** hdl/vdsc_top.sv ***
// APB register bank and control outputs for the oscillator dividers and sync
`timescale 1ns/1ns
module vdsc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic first_divider_run,
   output logic [3:0] first_divider_ratio,
   output logic second_divider_run,
   output logic [3:0] second_divider_ratio,
   output logic [3:0] output_divider_reset,
   output logic feedback_delay_divider_reset
);
   // ==========================================
   // Register and output state
   logic [7:0] ctl_r, ctl_nxt;
   logic [7:0] rat_r, rat_nxt;
   logic [7:0] msk_r, msk_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic [3:0] odr_r, odr_nxt;
   logic fdr_r, fdr_nxt;
   logic run0_r, run0_nxt;
   logic run1_r, run1_nxt;
   // Bus decode
   logic setup;
   logic access;
   logic write_ok;
   logic hit_ctl;
   logic hit_rat;
   logic hit_msk;
   logic hit_any;
   // Divider fields and sync reach
   logic [3:0] first_code;
   logic [3:0] second_code;
   logic first_sync;
   logic second_sync;
   logic [3:0] first_reach;
   logic [3:0] second_reach;

   // ==========================================
   // Helper functions

   // Ratio code divides only inside the valid band
   function automatic logic ratio_valid(input logic [3:0] code);
      ratio_valid = (code >= vdsc_pkg::VDSC_RATIO_MIN) && (code <= vdsc_pkg::VDSC_RATIO_MAX);
   endfunction

   // Whole word match; upper address bits must be zero
   function automatic logic addr_hit(input logic [31:0] addr, input logic [13:0] reg_addr);
      addr_hit = addr == 32'(reg_addr);
   endfunction

   // Runs only out of reset, powered up and with a valid code
   function automatic logic divider_runs(input logic hold, input logic down,
         input logic [3:0] code);
      divider_runs = !hold && !down && ratio_valid(code);
   endfunction

   // Register byte as a bus word, upper bits read 0
   function automatic logic [31:0] bus_word(input logic [7:0] value);
      bus_word = {24'h000000, value};
   endfunction

   // Sync reaches each fed output whose ignore bit is clear
   function automatic logic [3:0] sync_reach(input logic sync, input logic [3:0] ignore);
      sync_reach = {4{sync}} & ~ignore;
   endfunction

   // ==========================================
   // APB decode, zero wait states
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign write_ok = access && pwrite && pstrb[0];
   assign hit_ctl = addr_hit(paddr, vdsc_pkg::VDSC_ADDR_CONTROL);
   assign hit_rat = addr_hit(paddr, vdsc_pkg::VDSC_ADDR_RATIOS);
   assign hit_msk = addr_hit(paddr, vdsc_pkg::VDSC_ADDR_MASKS);
   assign hit_any = hit_ctl || hit_rat || hit_msk;
   assign pready = 1'b1;

   // Unmapped address answers with an error in the access phase
   assign pslverr = access && !hit_any;

   // ==========================================
   // Control register: reset, power-down and sync bits

   // Write lands at the access edge; reserved bits never stick
   always_comb begin
      ctl_nxt = ctl_r;
      if (write_ok && hit_ctl) begin
         ctl_nxt = pwdata[7:0] & vdsc_pkg::VDSC_CTL_WMASK; // RULE4 RULE9
      end
   end

   // Control flop; second divider starts powered down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_r <= vdsc_pkg::VDSC_CTL_RESET; // RULE9
      end else begin
         ctl_r <= ctl_nxt;
      end
   end

   // ==========================================
   // Ratio register: both divider codes

   // Every bit writable; out-of-band codes are legal and power down
   always_comb begin
      rat_nxt = rat_r;
      if (write_ok && hit_rat) begin
         rat_nxt = pwdata[7:0]; // RULE5 RULE6
      end
   end

   // Ratio flop; both codes start at their default
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rat_r <= vdsc_pkg::VDSC_RAT_RESET; // RULE5 RULE6
      end else begin
         rat_r <= rat_nxt;
      end
   end

   // ==========================================
   // Mask register: outputs that ignore a sync

   // Write lands at the access edge; reserved bit never sticks
   always_comb begin
      msk_nxt = msk_r;
      if (write_ok && hit_msk) begin
         msk_nxt = pwdata[7:0] & vdsc_pkg::VDSC_MSK_WMASK; // RULE7 RULE8
      end
   end

   // Mask flop; nothing masked after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msk_r <= vdsc_pkg::VDSC_MSK_RESET; // RULE7
      end else begin
         msk_r <= msk_nxt;
      end
   end

   // ==========================================
   // Read data, captured in the setup cycle

   // A write ending just before the setup edge is already visible here
   always_comb begin
      prdata_nxt = prdata_r;
      if (setup) begin
         if (hit_ctl) begin
            prdata_nxt = bus_word(ctl_r);
         end else if (hit_rat) begin
            prdata_nxt = bus_word(rat_r);
         end else if (hit_msk) begin
            prdata_nxt = bus_word(msk_r);
         end else begin
            prdata_nxt = 32'h00000000;
         end
      end
   end

   // Read data flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else begin
         prdata_r <= prdata_nxt;
      end
   end

   // Read data shown only while the access phase lasts
   assign prdata = access ? prdata_r : 32'h00000000;

   // ==========================================
   // Divider run enables
   assign first_code = rat_r[vdsc_pkg::VDSC_RAT_FIRST_LSB +: 4];
   assign second_code = rat_r[vdsc_pkg::VDSC_RAT_SECOND_LSB +: 4];

   // Enables follow a register write by one clock
   always_comb begin
      run0_nxt = divider_runs(ctl_r[vdsc_pkg::VDSC_CTL_FIRST_RESET],
         ctl_r[vdsc_pkg::VDSC_CTL_FIRST_PD], first_code); // RULE4 RULE5 RULE9
      run1_nxt = divider_runs(ctl_r[vdsc_pkg::VDSC_CTL_SECOND_RESET],
         ctl_r[vdsc_pkg::VDSC_CTL_SECOND_PD], second_code); // RULE4 RULE6 RULE9
   end

   // Run flops; both stopped while in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run0_r <= 1'b0;
         run1_r <= 1'b0;
      end else begin
         run0_r <= run0_nxt;
         run1_r <= run1_nxt;
      end
   end

   // ==========================================
   // Distribution sync holds
   assign first_sync = ctl_r[vdsc_pkg::VDSC_CTL_FIRST_SYNC]; // RULE2
   assign second_sync = ctl_r[vdsc_pkg::VDSC_CTL_SECOND_SYNC]; // RULE1

   // First sync feeds outputs zero to three
   assign first_reach = sync_reach(first_sync,
      msk_r[vdsc_pkg::VDSC_MSK_FIRST_LSB +: 4]); // RULE8

   // Second sync feeds outputs one and two only; zero and three never see it
   assign second_reach = sync_reach(second_sync, {1'b1, msk_r[vdsc_pkg::VDSC_MSK_SECOND_TWO],
      msk_r[vdsc_pkg::VDSC_MSK_SECOND_ONE], 1'b1}); // RULE7

   // Holds from both syncs combine; levels follow the bits, no self-clear
   always_comb begin
      odr_nxt = first_reach | second_reach; // RULE3
      fdr_nxt = first_sync && !msk_r[vdsc_pkg::VDSC_MSK_FIRST_FEEDBACK]; // RULE3 RULE8
   end

   // Hold flops; nothing held after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         odr_r <= 4'h0;
         fdr_r <= 1'b0;
      end else begin
         odr_r <= odr_nxt;
         fdr_r <= fdr_nxt;
      end
   end

   // ==========================================
   // Output ports
   assign first_divider_run = run0_r;
   assign second_divider_run = run1_r;
   assign first_divider_ratio = first_code;
   assign second_divider_ratio = second_code;
   assign output_divider_reset = odr_r;
   assign feedback_delay_divider_reset = fdr_r;
endmodule
